// ==== inc/cppc_consts.svh ====
// constants for the charge port power control block
`ifndef CPPC_CONSTS_SVH
`define CPPC_CONSTS_SVH

`define CPPC_NUM_PORTS      2
`define CPPC_CHG_REG_ADDR   8'hD0
`define CPPC_CHG_BIT_PORT1  1
`define CPPC_CHG_BIT_PORT2  2
`define CPPC_CFG_SEL_STRAP  1'h0
`define CPPC_CFG_SEL_SERIAL 1'h1
`define CPPC_STRAP_HIGH     1'h1
`define CPPC_OC_FILT_LEN    2
`define CPPC_SYNC_SETTLE    2'h2

`endif

// ==== inc/cppc_pkg.sv ====
// types for the charge port power control block
package cppc_pkg;

  typedef enum logic [2:0] {
    CPPC_ST_RESET  = 3'h1,
    CPPC_ST_CONFIG = 3'h2,
    CPPC_ST_RUN    = 3'h4
  } cppc_state_type;

endpackage : cppc_pkg

// ==== rtl/cppc_port_lock.sv ====
// per-port over-current lockout and power output register
`timescale 1ns/10ps
`default_nettype none

module cppc_port_lock (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic running,
  input  wire logic chargeEn,
  input  wire logic busResetPulse,
  input  wire logic hostPowerOn,
  input  wire logic hostPowerOff,
  input  wire logic overCurrent,
  output logic      portPower,
  output logic      ocStatus
);

  logic lock_q;
  logic hostOn_q;

  // --------------------------------------------------------------
  // lockout flag
  // --------------------------------------------------------------
  // a fault in the same cycle as a host request wins, so no fault is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= 1'b0;
    end else if (running && overCurrent) begin
      lock_q <= 1'b1;
    end else if (hostPowerOn) begin
      lock_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // host power request state
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hostOn_q <= 1'b0;
    end else if (busResetPulse || hostPowerOff) begin
      hostOn_q <= 1'b0;
    end else if (hostPowerOn) begin
      hostOn_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      portPower <= 1'b0;
      ocStatus  <= 1'b0;
    end else begin
      portPower <= running && !lock_q && !overCurrent
                   && (chargeEn || hostOn_q);
      ocStatus  <= running && overCurrent;
    end
  end

endmodule : cppc_port_lock

`default_nettype wire

// ==== rtl/cppc_power_ctrl.sv ====
// charge port power control: top level
//
// Function
// - charging enable per port by serial; strap enables port 1 only
// - straps honoured only in strap mode
// - straps ignored unless config selects them
// - charging ports powered after reset and config
// - no wait for enumeration or vbus sense
// - over-current removes that port's power
// - lockout held until host request or reset
// - persisting over-current reported in port status
// - host powers port when no fault remains
// - select 0 straps, select 1 serial bus
// - charge register bits 1,2 enable ports
// - bus reset drops host power; lockout and charging enable kept
`timescale 1ns/10ps
`default_nettype none
`include "cppc_consts.svh"

module cppc_power_ctrl #(
  parameter int NumPorts = `CPPC_NUM_PORTS
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                cfgSelPin,
  input  wire logic                port1_charge_strap,
  input  wire logic                upstream_vbus_sense,
  input  wire logic                serialWrite,
  input  wire logic [7:0]          serialAddr,
  input  wire logic [7:0]          serialData,
  input  wire logic                configDone,
  input  wire logic                busReset,
  input  wire logic [NumPorts-1:0] hostPowerOn,
  input  wire logic [NumPorts-1:0] hostPowerOff,
  input  wire logic [NumPorts-1:0] overCurrentN,
  output logic [NumPorts-1:0]      port_power_out,
  output logic [NumPorts-1:0]      portOcStatus,
  output cppc_pkg::cppc_state_type ctrlState
);
  import cppc_pkg::*;

  if (NumPorts != 2) begin : gBadPorts
    $error("cppc_power_ctrl serves exactly two ports");
  end

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  // pins are asynchronous; the first stage feeds only the second
  logic [NumPorts+3:0] pinMeta_q;
  logic [NumPorts+3:0] pinSync_q;
  logic                cfgSel;
  logic                strapSync;
  logic                cfgDoneSync;
  logic                busRstSync;
  logic [NumPorts-1:0] ocSync;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= {~overCurrentN, busReset, configDone,
                    port1_charge_strap, cfgSelPin};
      pinSync_q <= pinMeta_q;
    end
  end

  assign cfgSel      = pinSync_q[0];
  assign strapSync   = pinSync_q[1];
  assign cfgDoneSync = pinSync_q[2];
  assign busRstSync  = pinSync_q[3];
  assign ocSync      = pinSync_q[NumPorts+3:4];

  // --------------------------------------------------------------
  // synchroniser settle
  // --------------------------------------------------------------
  // both stages come out of reset holding zeros, so the straps and
  // the select pin mean nothing until real pin values have arrived
  logic [1:0] settleCnt_q;
  logic       pinsValid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settleCnt_q <= 2'h0;
    end else if (settleCnt_q != `CPPC_SYNC_SETTLE) begin
      settleCnt_q <= settleCnt_q + 2'h1;
    end
  end

  assign pinsValid = (settleCnt_q == `CPPC_SYNC_SETTLE);

  // --------------------------------------------------------------
  // bus reset edge
  // --------------------------------------------------------------
  logic busRstPrev_q;
  logic busRstPulse;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busRstPrev_q <= 1'b0;
    end else begin
      busRstPrev_q <= busRstSync;
    end
  end

  assign busRstPulse = busRstSync && !busRstPrev_q;

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  cppc_state_type state_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CPPC_ST_RESET;
    end else begin
      case (state_q)
        CPPC_ST_RESET: begin
          if (pinsValid) begin
            state_q <= CPPC_ST_CONFIG;
          end
        end
        CPPC_ST_CONFIG: begin
          // strap mode needs no load; serial mode waits for it
          // vbus sense and enumeration deliberately play no part
          if (cfgSel == `CPPC_CFG_SEL_STRAP || cfgDoneSync) begin
            state_q <= CPPC_ST_RUN;
          end
        end
        CPPC_ST_RUN: begin
          state_q <= CPPC_ST_RUN;
        end
        default: begin
          state_q <= CPPC_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlState <= CPPC_ST_RESET;
    end else begin
      ctrlState <= state_q;
    end
  end

  // --------------------------------------------------------------
  // strap capture
  // --------------------------------------------------------------
  // caught once, on leaving reset, so later pin noise is harmless
  logic strapCharge_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strapCharge_q <= 1'b0;
    end else if (state_q == CPPC_ST_RESET && pinsValid) begin
      strapCharge_q <= (strapSync == `CPPC_STRAP_HIGH);
    end
  end

  // --------------------------------------------------------------
  // charging register
  // --------------------------------------------------------------
  logic [7:0] chargeReg_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chargeReg_q <= 8'h00;
    end else if (serialWrite && serialAddr == `CPPC_CHG_REG_ADDR
                 && cfgSel == `CPPC_CFG_SEL_SERIAL) begin
      chargeReg_q <= serialData;
    end
  end

  // --------------------------------------------------------------
  // per-port charge enable
  // --------------------------------------------------------------
  logic [NumPorts-1:0] chargeEn;

  always_comb begin
    if (cfgSel == `CPPC_CFG_SEL_STRAP) begin
      // only port 1 has a strap; others stay off
      chargeEn    = '0;
      chargeEn[0] = strapCharge_q;
    end else begin
      chargeEn    = '0;
      chargeEn[0] = chargeReg_q[`CPPC_CHG_BIT_PORT1];
      chargeEn[1] = chargeReg_q[`CPPC_CHG_BIT_PORT2];
    end
  end

  // --------------------------------------------------------------
  // port instances
  // --------------------------------------------------------------
  logic running;

  assign running = (state_q == CPPC_ST_RUN);

  for (genvar p = 0; p < NumPorts; p++) begin : gPort
    cppc_port_lock uLock (
      .clk           (clk),
      .rstn          (rstn),
      .running       (running),
      .chargeEn      (chargeEn[p]),
      .busResetPulse (busRstPulse),
      .hostPowerOn   (hostPowerOn[p]),
      .hostPowerOff  (hostPowerOff[p]),
      .overCurrent   (ocSync[p]),
      .portPower     (port_power_out[p]),
      .ocStatus      (portOcStatus[p])
    );
  end

  // vbus sense is accepted but unused: power never waits for it
  logic unusedVbus;
  assign unusedVbus = upstream_vbus_sense;

endmodule : cppc_power_ctrl

`default_nettype wire

// ==== tb/cppc_power_ctrl_sva.sv ====
// assertion checker for charge port power control
`timescale 1ns/10ps
`default_nettype none
module cppc_power_ctrl_sva #(
  parameter int NumPorts = 2
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                cfgSelPin,
  input wire logic                port1_charge_strap,
  input wire logic [NumPorts-1:0] hostPowerOn,
  input wire logic [NumPorts-1:0] hostPowerOff,
  input wire logic [NumPorts-1:0] overCurrentN,
  input wire logic [NumPorts-1:0] port_power_out,
  input wire logic [NumPorts-1:0] portOcStatus,
  input wire cppc_pkg::cppc_state_type ctrlState
);
  import cppc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_state_onehot: assert property ($onehot(ctrlState))
    else $error("state not one-hot");
  chk_run_sticky: assert property
    (ctrlState == CPPC_ST_RUN |=> ctrlState == CPPC_ST_RUN)
    else $error("left run state without reset");
  chk_reset_next: assert property
    (ctrlState == CPPC_ST_RESET |=> ctrlState != CPPC_ST_RUN)
    else $error("skipped config state");
  chk_power_run: assert property
    (|port_power_out |-> ctrlState == CPPC_ST_RUN)
    else $error("power before config done");
  chk_oc_off: assert property
    (!overCurrentN[0] [*4] |=> !port_power_out[0])
    else $error("power kept during fault");
  chk_oc_status: assert property
    ((!overCurrentN[0] && ctrlState == CPPC_ST_RUN) [*5] |-> portOcStatus[0])
    else $error("fault not reported");
  chk_status_clear: assert property
    (overCurrentN[0] [*5] |-> !portOcStatus[0])
    else $error("stale fault status");
  chk_strap_power: assert property
    ($rose(ctrlState == CPPC_ST_RUN) && !cfgSelPin && port1_charge_strap
     && overCurrentN[0] |-> ##[1:3] port_power_out[0])
    else $error("strap port not powered");
  chk_host_on: assert property
    (overCurrentN[0] [*5] ##0 (hostPowerOn[0] && !hostPowerOff[0]
     && ctrlState == CPPC_ST_RUN) |-> ##[1:3] port_power_out[0])
    else $error("host power request lost");
endmodule : cppc_power_ctrl_sva

bind cppc_power_ctrl cppc_power_ctrl_sva #(.NumPorts(NumPorts)) u_sva (
  .clk, .rstn, .cfgSelPin, .port1_charge_strap, .hostPowerOn, .hostPowerOff,
  .overCurrentN, .port_power_out, .portOcStatus, .ctrlState);
`default_nettype wire

// ==== tb/cppc_switch_model.sv ====
// behavioural port power switch with over-current flag
`timescale 1ns/10ps
`default_nettype none
module cppc_switch_model #(
  parameter int NumPorts = 2
) (
  input  wire logic [NumPorts-1:0] shortLoad,
  output logic      [NumPorts-1:0] overCurrentN
);
  // open-drain flag with pull-up: released reads high, held while shorted
  always_comb overCurrentN = ~shortLoad;
endmodule : cppc_switch_model
`default_nettype wire

// ==== tb/test_charge_port_power_control.sv ====
// self-checking bench for charge port power control
`timescale 1ns/10ps
`default_nettype none
module test_charge_port_power_control;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       cfgSel = 1'b0;
  logic       strap = 1'b1;
  logic       sWr = 1'b0;
  logic [7:0] sAddr = 8'h00;
  logic [7:0] sData = 8'h00;
  logic       cfgDone = 1'b0;
  logic       busRst = 1'b0;
  logic [1:0] hostOn = 2'h0;
  logic [1:0] hostOff = 2'h0;
  logic [1:0] shortLoad = 2'h0;
  logic [1:0] ocN;
  logic [1:0] pwr;
  logic [1:0] ocStat;
  int         bad_count = 0;
  int         n_checks = 0;
  always #50 clk = ~clk;
  cppc_switch_model #(.NumPorts(2)) sw (.shortLoad(shortLoad),
    .overCurrentN(ocN));
  cppc_power_ctrl #(.NumPorts(2)) dut (.clk(clk), .rstn(rstn),
    .cfgSelPin(cfgSel), .port1_charge_strap(strap),
    .upstream_vbus_sense(1'b0), .serialWrite(sWr), .serialAddr(sAddr),
    .serialData(sData), .configDone(cfgDone), .busReset(busRst),
    .hostPowerOn(hostOn), .hostPowerOff(hostOff), .overCurrentN(ocN),
    .port_power_out(pwr), .portOcStatus(ocStat), .ctrlState());
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [1:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // sample one time unit after the edge so design updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_pwr(input logic [1:0] exp);
    for (int i = 0; i < 20 && pwr !== exp; i++) tick(1);
    check("port power", exp, pwr);
    if (pwr !== exp) report_and_stop();
  endtask : wait_pwr
  task automatic do_reset(input logic sel, st);
    @(posedge clk);
    rstn <= 1'b0;
    cfgSel <= sel;
    strap <= st;
    cfgDone <= 1'b0;
    shortLoad <= 2'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
  endtask : do_reset
  task automatic swrite(input logic [7:0] a, d);
    @(posedge clk);
    sWr <= 1'b1;
    sAddr <= a;
    sData <= d;
    @(posedge clk);
    sWr <= 1'b0;
  endtask : swrite
  task automatic host_pulse(input logic [1:0] on, off);
    @(posedge clk);
    hostOn <= on;
    hostOff <= off;
    @(posedge clk);
    hostOn <= 2'h0;
    hostOff <= 2'h0;
  endtask : host_pulse
  task automatic bus_reset;
    @(posedge clk);
    busRst <= 1'b1;
    repeat (4) @(posedge clk);
    busRst <= 1'b0;
  endtask : bus_reset
  task automatic t_strap;
    do_reset(1'b0, 1'b1);
    wait_pwr(2'h1);
    tick(20);
    check("no vbus power", 2'h1, pwr);
    swrite(8'hD0, 8'h06);
    tick(5);
    check("strap mode write", 2'h1, pwr);
  endtask : t_strap
  task automatic t_fault;
    @(posedge clk);
    shortLoad <= 2'h1;
    wait_pwr(2'h0);
    tick(3);
    check("fault status", 2'h1, ocStat);
    @(posedge clk);
    shortLoad <= 2'h0;
    tick(10);
    check("lockout power", 2'h0, pwr);
    check("fault cleared", 2'h0, ocStat);
    host_pulse(2'h1, 2'h0);
    wait_pwr(2'h1);
    @(posedge clk);
    shortLoad <= 2'h1;
    wait_pwr(2'h0);
    do_reset(1'b0, 1'b1);
    wait_pwr(2'h1);
  endtask : t_fault
  task automatic t_host;
    do_reset(1'b0, 1'b1);
    wait_pwr(2'h1);
    host_pulse(2'h2, 2'h0);
    wait_pwr(2'h3);
    host_pulse(2'h0, 2'h2);
    wait_pwr(2'h1);
    host_pulse(2'h2, 2'h0);
    wait_pwr(2'h3);
    bus_reset();
    wait_pwr(2'h1);
    tick(5);
    check("bus reset off", 2'h1, pwr);
  endtask : t_host
  task automatic t_serial;
    do_reset(1'b1, 1'b1);
    tick(3);
    swrite(8'hD0, 8'h04);
    swrite(8'h55, 8'h06);
    tick(3);
    check("before config", 2'h0, pwr);
    @(posedge clk);
    cfgDone <= 1'b1;
    wait_pwr(2'h2);
    swrite(8'hD0, 8'h06);
    wait_pwr(2'h3);
    bus_reset();
    tick(10);
    check("bus reset power", 2'h3, pwr);
  endtask : t_serial
  initial begin
    t_strap();
    t_fault();
    t_host();
    t_serial();
    report_and_stop();
  end
endmodule : test_charge_port_power_control
`default_nettype wire
